// [common/mks_pkg.sv]
// constants shared by the keypad and switch scanner
package mks_pkg;

    // ========================================
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_KEYVAL = 8'h04;
    localparam logic [7:0] OFF_KEYSTAT = 8'h08;
    localparam logic [7:0] OFF_SW0 = 8'h0C;
    localparam logic [7:0] OFF_SW1 = 8'h10;
    localparam logic [7:0] OFF_IRQSTAT = 8'h14;
    localparam logic [7:0] OFF_IRQMASK = 8'h18;

    // ========================================
    // control bits
    localparam int CB_KEY_EN = 0;
    localparam int CB_HEX_MODE = 1;
    localparam int CB_SW_EN = 2;
    localparam int CB_SW_TWO = 3;
    localparam int CTRL_W = 4;

    // ========================================
    // keypad status bits
    localparam int ST_FLAGS_LSB = 0;
    localparam int LETTER_N = 6;
    localparam int ST_LETTER = 6;
    localparam int ST_DIGIT = 7;
    localparam int ST_DONE = 8;
    localparam int KEYSTAT_W = 9;

    // ========================================
    // interrupt bits
    localparam int IB_KEY = 0;
    localparam int IB_LETTER = 1;
    localparam int IB_DIGIT = 2;
    localparam int IB_SW = 3;
    localparam int IRQ_N = 4;

    // ========================================
    // scan structure and arithmetic
    localparam int STROBES = 4;
    localparam logic [2:0] KEY_PH_LAST = 3'h7;
    localparam logic [1:0] SW_PH_LAST = 2'h3;
    localparam logic [3:0] LETTER_BASE = 4'hA;
    localparam logic [15:0] DEC_MOD = 16'h03E8;
    localparam logic [15:0] DEC_BASE = 16'h000A;

    // ========================================
    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int SCAN_TIME_US = 1000;
    localparam int SCAN_CYCLES = SCAN_TIME_US * 1000 / CLK_PERIOD_NS;

    // ========================================
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [logic/mks_key_pick.sv]
// lowest-index picker among newly pressed keys
`timescale 1ns/1ps

module mks_key_pick #(
    parameter int N = 16,
    parameter int W = 4
) (
    input wire logic [N-1:0] req,
    output logic valid,
    output logic [W-1:0] idx
);

    if (N < 2 || N > (1 << W)) begin : g_chk
        $error("mks_key_pick: N does not fit W");
    end

    // ========================================
    // scan down so the lowest set request wins
    always_comb begin
        valid = 1'b0;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                valid = 1'b1;
                idx = W'(i);
            end
        end
    end

endmodule

// [logic/mks_bcd_to_bin.sv]
// decimal digit group to binary converter
`timescale 1ns/1ps

module mks_bcd_to_bin #(
    parameter int DIGITS = 4
) (
    input wire logic [4*DIGITS-1:0] digits,
    output logic [15:0] bin
);

    if (DIGITS < 1 || DIGITS > 4) begin : g_chk
        $error("mks_bcd_to_bin: DIGITS must be 1 to 4");
    end

    // ========================================
    // horner form, top nibble is the most significant digit
    always_comb begin
        bin = '0;
        for (int i = DIGITS - 1; i >= 0; i--) begin
            bin = 16'(bin * mks_pkg::DEC_BASE + 16'(digits[i*4 +: 4]));
        end
    end

endmodule

// [logic/mks_scanner.sv]
// keypad matrix and decimal switch scanner with axi4-lite registers
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps

module mks_scanner #(
    parameter int ADDR_W = 8,
    parameter int SCAN_CYCLES = mks_pkg::SCAN_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic [3:0] keyStrobe,
    input wire logic [3:0] keySense,
    output logic [3:0] swStrobe,
    input wire logic [7:0] swSense,
    output logic irq
);

    if (ADDR_W < 5 || ADDR_W > 32) begin : g_chk_addr
        $error("mks_scanner: ADDR_W must be 5 to 32");
    end
    if (SCAN_CYCLES < 2) begin : g_chk_scan
        $error("mks_scanner: SCAN_CYCLES must be at least 2");
    end

    localparam int TW = $clog2(SCAN_CYCLES);

    // ========================================
    // scan cycle timebase
    logic [TW-1:0] tickCnt_r;
    logic scanTick;
    assign scanTick = (tickCnt_r == TW'(SCAN_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tickCnt_r <= '0;
        end else begin
            tickCnt_r <= scanTick ? '0 : tickCnt_r + 1'b1;
        end
    end

    // ========================================
    // control and interrupt registers
    logic keyEn_r;
    logic hexMode_r;
    logic swEn_r;
    logic swTwo_r;
    logic [mks_pkg::IRQ_N-1:0] irqStat_r;
    logic [mks_pkg::IRQ_N-1:0] irqMask_r;

    // ========================================
    // keypad state
    logic [2:0] keyPhase_r;
    logic [11:0] keyBuf_r;
    logic [15:0] prevMat_r;
    logic heldValid_r;
    logic [3:0] heldIdx_r;
    logic [15:0] keyVal_r;
    logic [5:0] letterFlags_r;
    logic letterPulse_r;
    logic digitPulse_r;
    logic keyDone_r;

    // last strobe's senses arrive live, earlier strobes come from the buffer
    wire keyEnd = keyEn_r && scanTick && (keyPhase_r == mks_pkg::KEY_PH_LAST);
    wire [15:0] curMat = {keySense, keyBuf_r};
    wire [15:0] newPress = curMat & ~prevMat_r;
    wire heldStill = heldValid_r && curMat[heldIdx_r];
    wire pickValid;
    wire [3:0] pickIdx;

    mks_key_pick #(
        .N(16),
        .W(4)
    ) uPick (
        .req(newPress),
        .valid(pickValid),
        .idx(pickIdx)
    );

    // a key still held blocks every later one
    wire keyAccept = keyEnd && pickValid && !heldStill;
    wire isDigit = pickIdx < mks_pkg::LETTER_BASE;
    wire [15:0] keyMod = keyVal_r % mks_pkg::DEC_MOD;
    wire [15:0] keyDec = 16'(keyMod * mks_pkg::DEC_BASE + 16'(pickIdx));
    wire [15:0] keyHex = {keyVal_r[11:0], pickIdx};
    wire [2:0] letterPos = 3'(pickIdx - mks_pkg::LETTER_BASE);
    wire takeValue = hexMode_r || isDigit;

    // strobe k stays on for two phases, senses read at the second
    assign keyStrobe = keyEn_r ? (4'h1 << keyPhase_r[2:1]) : 4'h0;

    always_ff @(posedge clk) begin
        if (!rst_b || !keyEn_r) begin
            keyPhase_r <= '0;
            keyBuf_r <= '0;
            prevMat_r <= '0;
            heldValid_r <= 1'b0;
            heldIdx_r <= '0;
        end else if (scanTick) begin
            keyPhase_r <= keyPhase_r + 3'h1;
            if (keyPhase_r[0]) begin
                keyBuf_r <= {keySense, keyBuf_r[11:4]};
            end
            if (keyEnd) begin
                prevMat_r <= curMat;
                if (keyAccept) begin
                    heldValid_r <= 1'b1;
                    heldIdx_r <= pickIdx;
                end else if (!heldStill) begin
                    heldValid_r <= 1'b0;
                end
            end
        end
    end

    // value survives a disable, flags do not
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            keyVal_r <= '0;
        end else if (keyAccept && takeValue) begin
            keyVal_r <= hexMode_r ? keyHex : keyDec;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || !keyEn_r) begin
            letterFlags_r <= '0;
            letterPulse_r <= 1'b0;
            digitPulse_r <= 1'b0;
            keyDone_r <= 1'b0;
        end else if (scanTick) begin
            if (keyAccept && !isDigit) begin
                letterFlags_r <= 6'h01 << letterPos;
            end
            letterPulse_r <= keyAccept && !isDigit;
            digitPulse_r <= keyAccept && isDigit;
            keyDone_r <= keyAccept;
        end
    end

    // ========================================
    // switch reader
    logic [1:0] swPhase_r;
    logic [11:0] swBufA_r;
    logic [11:0] swBufB_r;
    logic [15:0] swRes0_r;
    logic [15:0] swRes1_r;
    logic swDone_r;
    wire swEnd = swEn_r && scanTick && (swPhase_r == mks_pkg::SW_PH_LAST);
    wire [15:0] swBin0;
    wire [15:0] swBin1;

    // both groups see the same strobe, each its own nibble
    assign swStrobe = swEn_r ? (4'h1 << swPhase_r) : 4'h0;

    // first strobe reads the thousands digit
    mks_bcd_to_bin #(
        .DIGITS(4)
    ) uBcd0 (
        .digits({swBufA_r, swSense[3:0]}),
        .bin(swBin0)
    );

    mks_bcd_to_bin #(
        .DIGITS(4)
    ) uBcd1 (
        .digits({swBufB_r, swSense[7:4]}),
        .bin(swBin1)
    );

    always_ff @(posedge clk) begin
        if (!rst_b || !swEn_r) begin
            swPhase_r <= '0;
            swBufA_r <= '0;
            swBufB_r <= '0;
            swDone_r <= 1'b0;
        end else if (scanTick) begin
            swPhase_r <= swPhase_r + 2'h1;
            swBufA_r <= {swBufA_r[7:0], swSense[3:0]};
            swBufB_r <= {swBufB_r[7:0], swSense[7:4]};
            swDone_r <= swEnd;
        end
    end

    // a pass cut short by disable leaves the old results in place
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            swRes0_r <= '0;
            swRes1_r <= '0;
        end else if (swEnd) begin
            swRes0_r <= swBin0;
            if (swTwo_r) begin
                swRes1_r <= swBin1;
            end
        end
    end

    // ========================================
    // interrupt events
    logic [mks_pkg::IRQ_N-1:0] irqSet;
    assign irqSet[mks_pkg::IB_KEY] = keyAccept;
    assign irqSet[mks_pkg::IB_LETTER] = keyAccept && !isDigit;
    assign irqSet[mks_pkg::IB_DIGIT] = keyAccept && isDigit;
    assign irqSet[mks_pkg::IB_SW] = swEnd;
    assign irq = |(irqStat_r & irqMask_r);

    // ========================================
    // axi4-lite write path
    logic awHeld_r;
    logic wHeld_r;
    logic [ADDR_W-1:0] awAddr_r;
    logic [31:0] wData_r;
    logic wLane0_r;
    logic bvalid_r;
    logic [1:0] bresp_r;

    wire [ADDR_W-1:0] wA = {awAddr_r[ADDR_W-1:2], 2'b00};
    wire wCtrl = wA == ADDR_W'(mks_pkg::OFF_CTRL);
    wire wStat = wA == ADDR_W'(mks_pkg::OFF_IRQSTAT);
    wire wMask = wA == ADDR_W'(mks_pkg::OFF_IRQMASK);
    wire wRo = wA == ADDR_W'(mks_pkg::OFF_KEYVAL)
        || wA == ADDR_W'(mks_pkg::OFF_KEYSTAT)
        || wA == ADDR_W'(mks_pkg::OFF_SW0)
        || wA == ADDR_W'(mks_pkg::OFF_SW1);
    wire wHit = wCtrl || wStat || wMask || wRo;
    wire doWrite = awHeld_r && wHeld_r && !bvalid_r;
    wire wLow = doWrite && wLane0_r;
    wire [mks_pkg::IRQ_N-1:0] irqClr =
        (wLow && wStat) ? wData_r[mks_pkg::IRQ_N-1:0] : '0;

    assign awready = !awHeld_r && !bvalid_r;
    assign wready = !wHeld_r && !bvalid_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= '0;
            wData_r <= '0;
            wLane0_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= mks_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld_r <= 1'b1;
                wData_r <= wdata;
                wLane0_r <= wstrb[0];
            end
            if (doWrite) begin
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wHit ? mks_pkg::RESP_OKAY : mks_pkg::RESP_SLVERR;
            end else if (bvalid_r && bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // a new event beats a write-one clear of the same bit
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            keyEn_r <= 1'b0;
            hexMode_r <= 1'b0;
            swEn_r <= 1'b0;
            swTwo_r <= 1'b0;
            irqMask_r <= '0;
            irqStat_r <= '0;
        end else begin
            if (wLow && wCtrl) begin
                keyEn_r <= wData_r[mks_pkg::CB_KEY_EN];
                hexMode_r <= wData_r[mks_pkg::CB_HEX_MODE];
                swEn_r <= wData_r[mks_pkg::CB_SW_EN];
                swTwo_r <= wData_r[mks_pkg::CB_SW_TWO];
            end
            if (wLow && wMask) begin
                irqMask_r <= wData_r[mks_pkg::IRQ_N-1:0];
            end
            irqStat_r <= (irqStat_r & ~irqClr) | irqSet;
        end
    end

    // ========================================
    // axi4-lite read path
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [mks_pkg::CTRL_W-1:0] ctrlBits;
    logic [mks_pkg::KEYSTAT_W-1:0] keyStat;

    assign ctrlBits[mks_pkg::CB_KEY_EN] = keyEn_r;
    assign ctrlBits[mks_pkg::CB_HEX_MODE] = hexMode_r;
    assign ctrlBits[mks_pkg::CB_SW_EN] = swEn_r;
    assign ctrlBits[mks_pkg::CB_SW_TWO] = swTwo_r;
    assign keyStat[mks_pkg::ST_FLAGS_LSB +: mks_pkg::LETTER_N] = letterFlags_r;
    assign keyStat[mks_pkg::ST_LETTER] = letterPulse_r;
    assign keyStat[mks_pkg::ST_DIGIT] = digitPulse_r;
    assign keyStat[mks_pkg::ST_DONE] = keyDone_r || swDone_r;

    wire [ADDR_W-1:0] rA = {araddr[ADDR_W-1:2], 2'b00};
    wire rCtrl = rA == ADDR_W'(mks_pkg::OFF_CTRL);
    wire rKval = rA == ADDR_W'(mks_pkg::OFF_KEYVAL);
    wire rKst = rA == ADDR_W'(mks_pkg::OFF_KEYSTAT);
    wire rSw0 = rA == ADDR_W'(mks_pkg::OFF_SW0);
    wire rSw1 = rA == ADDR_W'(mks_pkg::OFF_SW1);
    wire rStat = rA == ADDR_W'(mks_pkg::OFF_IRQSTAT);
    wire rMask = rA == ADDR_W'(mks_pkg::OFF_IRQMASK);
    wire rHit = rCtrl || rKval || rKst || rSw0 || rSw1 || rStat || rMask;
    wire [31:0] rData =
        rCtrl ? 32'(ctrlBits) :
        rKval ? 32'(keyVal_r) :
        rKst ? 32'(keyStat) :
        rSw0 ? 32'(swRes0_r) :
        rSw1 ? 32'(swRes1_r) :
        rStat ? 32'(irqStat_r) :
        rMask ? 32'(irqMask_r) : 32'h0000_0000;

    assign arready = !rvalid_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= mks_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_r <= 1'b1;
            rdata_r <= rData;
            rresp_r <= rHit ? mks_pkg::RESP_OKAY : mks_pkg::RESP_SLVERR;
        end else if (rvalid_r && rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ========================================
    // checks
    default clocking cbChk @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_keyTaken;
        keyAccept ##1 keyDone_r;
    endsequence

    sequence s_swTaken;
        swEnd ##1 swDone_r;
    endsequence

    property p_letter_once;
        letterPulse_r && scanTick |=> !letterPulse_r;
    endproperty
    a_letter_once: assert property (p_letter_once)
        else $error("letter pulse outlived one scan");

    property p_digit_once;
        digitPulse_r && scanTick |=> !digitPulse_r;
    endproperty
    a_digit_once: assert property (p_digit_once)
        else $error("digit pulse outlived one scan");

    property p_disable;
        !keyEn_r |=> letterFlags_r == 6'h00 && !letterPulse_r
            && !digitPulse_r && $stable(keyVal_r);
    endproperty
    a_disable: assert property (p_disable)
        else $error("disable did not clear flags or hold value");

    property p_onehot;
        $onehot0(letterFlags_r);
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("more than one letter flag set");

    property p_strobes;
        $onehot0(keyStrobe) && $onehot0(swStrobe);
    endproperty
    a_strobes: assert property (p_strobes)
        else $error("two strobes active together");

    property p_read_len;
        (keyAccept |-> scanTick && keyPhase_r == mks_pkg::KEY_PH_LAST) and
            (keyEn_r && scanTick |=>
                keyPhase_r == 3'($past(keyPhase_r) + 3'h1));
    endproperty
    a_read_len: assert property (p_read_len)
        else $error("key taken before full matrix read");

    property p_done_key;
        keyAccept |-> s_keyTaken;
    endproperty
    a_done_key: assert property (p_done_key)
        else $error("accepted key gave no done pulse");

    property p_first_wins;
        keyEnd && heldStill |-> !keyAccept
            ##1 ($stable(keyVal_r) && !keyDone_r);
    endproperty
    a_first_wins: assert property (p_first_wins)
        else $error("second key accepted while first held");

    property p_fn_key;
        keyAccept && !hexMode_r && !isDigit |=> $stable(keyVal_r);
    endproperty
    a_fn_key: assert property (p_fn_key)
        else $error("function key changed the value");

    property p_hex_digit;
        keyAccept && hexMode_r |=> keyVal_r[3:0] == $past(pickIdx);
    endproperty
    a_hex_digit: assert property (p_hex_digit)
        else $error("hex key not shifted into value");

    property p_sw_done;
        swEnd |-> s_swTaken ##1 (swDone_r && !scanTick)[*1];
    endproperty
    a_sw_done: assert property (p_sw_done)
        else $error("switch pass done pulse wrong");

    property p_sw_one;
        swEnd && !swTwo_r |=> $stable(swRes1_r) && swRes0_r == $past(swBin0);
    endproperty
    a_sw_one: assert property (p_sw_one)
        else $error("switch result words written wrongly");

endmodule

// [sim/mks_key_dip_model.sv]
// key matrix and decimal switch model for the scanner bench
`timescale 1ns/1ps

// ========================================
// far side: diodes pass a strobe to closed contacts only
module mks_key_dip_model (
    input wire logic [3:0] keyStrobe,
    input wire logic [3:0] swStrobe,
    input wire logic [15:0] keysDown,
    input wire logic [15:0] swDigits0,
    input wire logic [15:0] swDigits1,
    output logic [3:0] keySense,
    output logic [7:0] swSense
);
    // unstrobed senses read low: the input lines carry pull-downs
    always_comb begin
        keySense = 4'h0;
        swSense = 8'h00;
        for (int s = 0; s < 4; s++) begin
            if (keyStrobe[s]) begin
                keySense = keySense | keysDown[4*s +: 4];
            end
            // strobe 0 reaches the thousands digit of both groups
            if (swStrobe[s]) begin
                swSense = swSense | {swDigits1[12-4*s +: 4],
                                     swDigits0[12-4*s +: 4]};
            end
        end
    end
endmodule

// [sim/tb.sv]
// self-checking bench for the keypad and switch scanner
`timescale 1ns/1ps

module tb;
    localparam int SC = 4;
    localparam int LIMIT = 30000;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic [3:0] keyStrobe;
    logic [3:0] keySense;
    logic [3:0] swStrobe;
    logic [7:0] swSense;
    logic irq;
    logic [15:0] keysDown = 16'h0;
    logic [15:0] swDigits0 = 16'h0;
    logic [15:0] swDigits1 = 16'h0;
    logic [31:0] lfsr = 32'h10C5;
    logic [15:0] expVal = 16'h0;
    logic [5:0] expFlags = 6'h0;
    logic [15:0] expSw1 = 16'h0;
    logic expMask = 1'b0;
    logic hexMode = 1'b0;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;

    mks_scanner #(.ADDR_W(8), .SCAN_CYCLES(SC)) mks_scanner_i (
        .clk(clk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .keyStrobe(keyStrobe), .keySense(keySense), .swStrobe(swStrobe),
        .swSense(swSense), .irq(irq));

    mks_key_dip_model mks_key_dip_model_i (
        .keyStrobe(keyStrobe), .swStrobe(swStrobe), .keysDown(keysDown),
        .swDigits0(swDigits0), .swDigits1(swDigits1),
        .keySense(keySense), .swSense(swSense));

    initial begin
        forever #10 clk = ~clk;
    end

    // ========================================
    // helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [15:0] bcd2bin(input logic [15:0] x);
        return x[15:12] * 16'h03E8 + x[11:8] * 16'h0064
               + x[7:4] * 16'h000A + 16'(x[3:0]);
    endfunction

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg,
                     got, exp);
        end
    endtask

    // ========================================
    // bus master: requests move only just after a rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic aw;
        logic w;
        logic b;
        b = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b) begin
            @(negedge clk);
            aw = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            r = bresp;
            @(posedge clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        // an edge between calls keeps bready to one assignment per step
        @(posedge clk);
        chk({31'h0, b}, 32'h1, "write answer");
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        logic ar;
        logic g;
        g = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!g) begin
            @(negedge clk);
            ar = arvalid && arready;
            g = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ar) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        // an edge between calls keeps rready to one assignment per step
        @(posedge clk);
        chk({31'h0, g}, 32'h1, "read answer");
    endtask

    task automatic wrchk(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk({30'h0, r}, {30'h0, mks_pkg::RESP_OKAY}, "write resp");
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                         input string msg);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, e, msg);
        chk({30'h0, r}, {30'h0, mks_pkg::RESP_OKAY}, "read resp");
    endtask

    // ========================================
    // keypad: m2 joins m1 while m1 is still held
    task automatic press(input logic [15:0] m1, input logic [15:0] m2,
                         input int k);
        keysDown <= m1;
        cyc(80);
        keysDown <= m1 | m2;
        cyc(80);
        keysDown <= 16'h0;
        cyc(80);
        if (hexMode) expVal = {expVal[11:0], 4'(k)};
        else if (k < 10) expVal = (expVal % 16'h03E8) * 16'h000A + 16'(k);
        if (k > 9) expFlags = 6'h01 << (k - 10);
        rdchk(mks_pkg::OFF_KEYVAL, {16'h0, expVal}, "value");
        rdchk(mks_pkg::OFF_KEYSTAT, {26'h0, expFlags}, "flags");
        rdchk(mks_pkg::OFF_IRQSTAT, {29'h0, k < 10, k > 9, 1'b1}, "ev");
        chk({31'h0, irq}, {31'h0, expMask}, "irq");
        wrchk(mks_pkg::OFF_IRQSTAT, 32'h0000000F);
        chk({31'h0, irq}, 32'h0, "irq clear");
    endtask

    // ========================================
    // switches: software keeps the reader on until a pass is done
    task automatic sw_pass(input logic two, input logic [31:0] dg);
        logic [31:0] d;
        logic [1:0] r;
        int n;
        d = 32'h0;
        n = 0;
        wrchk(mks_pkg::OFF_CTRL, 32'h0);
        swDigits0 <= dg[15:0];
        swDigits1 <= dg[31:16];
        wrchk(mks_pkg::OFF_IRQSTAT, 32'h0000000F);
        wrchk(mks_pkg::OFF_CTRL, {28'h0, two, 3'b100});
        while (d[3] !== 1'b1 && n < 40) begin
            rd(mks_pkg::OFF_IRQSTAT, d, r);
            n++;
        end
        chk({31'h0, d[3]}, 32'h1, "pass done");
        chk({31'h0, irq}, 32'h0, "masked");
        if (two) expSw1 = bcd2bin(dg[31:16]);
        rdchk(mks_pkg::OFF_SW0, {16'h0, bcd2bin(dg[15:0])}, "sw0");
        rdchk(mks_pkg::OFF_SW1, {16'h0, expSw1}, "sw1");
        $display("test switch pass done");
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares++;
            wrap_up();
        end
    end

    // ========================================
    // main sequence
    initial begin
        logic [31:0] d;
        logic [31:0] dg;
        logic [1:0] r;
        cyc(5);
        rst_b <= 1'b1;
        cyc(1);
        rdchk(mks_pkg::OFF_CTRL, 32'h0, "ctrl reset");
        rdchk(mks_pkg::OFF_KEYVAL, 32'h0, "value reset");
        rdchk(mks_pkg::OFF_IRQMASK, 32'h0, "mask reset");
        rd(8'h40, d, r);
        chk({30'h0, r}, {30'h0, mks_pkg::RESP_SLVERR}, "unmapped rd");
        wr(8'h40, 32'h0000000F, r);
        chk({30'h0, r}, {30'h0, mks_pkg::RESP_SLVERR}, "unmapped wr");
        $display("test registers done");
        wrchk(mks_pkg::OFF_CTRL, 32'h00000001);
        press(16'h0020, 16'h0, 5);
        expMask = 1'b1;
        wrchk(mks_pkg::OFF_IRQMASK, 32'h00000001);
        press(16'h0400, 16'h0, 10);
        press(16'h2000, 16'h0, 13);
        press(16'h0200, 16'h0004, 9);
        press(16'h0050, 16'h0, 4);
        for (int i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            press(16'h0001 << lfsr[3:0], 16'h0, int'(lfsr[3:0]));
        end
        $display("test decimal keypad done");
        wrchk(mks_pkg::OFF_CTRL, 32'h0);
        expFlags = 6'h0;
        rdchk(mks_pkg::OFF_KEYVAL, {16'h0, expVal}, "kept");
        rdchk(mks_pkg::OFF_KEYSTAT, 32'h0, "cleared");
        hexMode = 1'b1;
        wrchk(mks_pkg::OFF_CTRL, 32'h00000003);
        press(16'h8000, 16'h0, 15);
        for (int i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            press(16'h0001 << lfsr[3:0], 16'h0, int'(lfsr[3:0]));
        end
        $display("test hex keypad done");
        sw_pass(1'b1, 32'h00009999);
        for (int i = 0; i < 2; i++) begin
            lfsr = lfsr_next(lfsr);
            for (int j = 0; j < 8; j++) dg[4*j +: 4] = lfsr[4*j +: 4] % 4'hA;
            sw_pass(i[0], dg);
        end
        wrap_up();
    end
endmodule
